// ### core/sel_loader.sv
// Purpose: Reset-time EEPROM default loader and software byte access.
// Assumes: Byte-wide configuration access at B0h-B3h on the same clock.
// Notes: Loaded values appear on the default outputs once valid is high.
`timescale 1ns/1ps
module sel_loader
    import sel_pkg::*;
#(
    parameter int QTR = QTR_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Configuration byte access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata_q,
    // Interface strap
    input wire logic serial_strap,
    // Serial clock pin
    input wire logic multipurpose_pin_four_i,
    output logic multipurpose_pin_four_o,
    output logic multipurpose_pin_four_oe,
    // Serial data pin
    input wire logic multipurpose_pin_one_i,
    output logic multipurpose_pin_one_o,
    output logic multipurpose_pin_one_oe,
    // Loaded defaults
    output logic dflt_valid_q,
    output logic [8:0] dflt_command,
    output logic [15:0] dflt_subsys_vendor,
    output logic [15:0] dflt_subsys_id,
    output logic [31:0] legacy_base_address,
    output logic [31:0] dflt_sys_ctrl,
    output logic [27:0] dflt_route,
    output logic [7:0] dflt_retry,
    output logic [7:0] dflt_card_ctrl,
    output logic [7:0] dflt_dev_ctrl,
    output logic [7:0] dflt_diag,
    output logic dflt_pm_cap15,
    output logic [7:0] dflt_socket_id,
    output logic dflt_force_evt27
);
    // ====================
    // State
    sel_st_e st_q;
    logic busy_q, wait_q, ld_q, abn_q;
    logic [4:0] idx_q;
    logic [1:0] boot_q;
    sel_byte_t data_q, index_q, target_q;
    logic quick_q, rdv_q, err_q, det_q;
    logic strap_m_q, strap_s_q;
    sel_byte_t ee_q [0:EE_BYTES-1];
    // ====================
    // Engine link
    sel_cmd_e cmd_w;
    sel_byte_t tx_w;
    logic ack_w;
    logic phy_done, phy_nack;
    sel_byte_t phy_rx;
    wire [6:0] tgt7 = ld_q ? EE_ADDR7 : target_q[7:1];
    wire phy_go = busy_q && !wait_q && (st_q != ST_IDLE)
        && (st_q != ST_BOOT);
    wire sw_start = cfg_wr && (cfg_addr == REG_TARGET)
        && (st_q == ST_IDLE);
    wire nack_st = (st_q == ST_ADDR_W) || (st_q == ST_INDEX)
        || (st_q == ST_DATA_W) || (st_q == ST_ADDR_R);
    wire err_set = phy_done && phy_nack && nack_st;
    wire rd_done = phy_done && (st_q == ST_DATA_R);
    wire store = rd_done && ld_q && !abn_q;
    wire sw_rd = rd_done && !ld_q;
    wire boot_end = (st_q == ST_BOOT) && (boot_q == 2'(BOOT_WAIT));
    wire det_set = boot_end && strap_s_q;
    wire ctrl_wr = cfg_wr && (cfg_addr == REG_CTRL);
    wire idle_wr = cfg_wr && (st_q == ST_IDLE);
    wire [7:0] csr = {2'b00, busy_q, 1'b0, det_q, err_q, rdv_q,
        quick_q};
    wire [7:0] rd_mux = (cfg_addr == REG_DATA) ? data_q
        : (cfg_addr == REG_INDEX) ? index_q
        : (cfg_addr == REG_TARGET) ? target_q
        : (cfg_addr == REG_CTRL) ? csr : 8'h00;

    always_comb begin
        cmd_w = CMD_BYTE;
        tx_w = 8'hFF;
        ack_w = 1'b1;
        unique case (st_q)
            ST_START, ST_RESTART: cmd_w = CMD_START;
            ST_STOP: cmd_w = CMD_STOP;
            ST_ADDR_W: tx_w = {tgt7, !ld_q && quick_q && target_q[0]};
            ST_INDEX: tx_w = ld_q ? EE_START : index_q;
            ST_ADDR_R: tx_w = {tgt7, 1'b1};
            ST_DATA_W: tx_w = data_q;
            ST_DATA_R: ack_w = !(ld_q && (idx_q != EE_LAST) && !abn_q);
            ST_BOOT, ST_IDLE: cmd_w = CMD_BYTE;
        endcase
    end

    sel_i2c_phy #(
        .QTR(QTR)
    ) u_phy (
        .clock(clock),
        .rst(rst),
        .go(phy_go),
        .cmd(cmd_w),
        .tx(tx_w),
        .ack_out(ack_w),
        .done_q(phy_done),
        .rx_q(phy_rx),
        .nack_q(phy_nack),
        .scl_i(multipurpose_pin_four_i),
        .scl_o(multipurpose_pin_four_o),
        .scl_oe_q(multipurpose_pin_four_oe),
        .sda_i(multipurpose_pin_one_i),
        .sda_o(multipurpose_pin_one_o),
        .sda_oe_q(multipurpose_pin_one_oe)
    );
    // ====================
    // Strap synchroniser
    always_ff @(posedge clock) begin
        strap_m_q <= serial_strap;
        strap_s_q <= strap_m_q;
    end
    // ====================
    // Transaction sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= ST_BOOT;
            boot_q <= 2'd0;
            busy_q <= 1'b0;
            wait_q <= 1'b0;
            ld_q <= 1'b0;
            abn_q <= 1'b0;
            idx_q <= 5'd0;
            dflt_valid_q <= 1'b0;
        end else if (st_q == ST_BOOT) begin
            boot_q <= boot_q + 2'd1;
            if (boot_end) begin
                st_q <= strap_s_q ? ST_START : ST_IDLE;
                busy_q <= strap_s_q;
                ld_q <= strap_s_q;
            end
        end else if (phy_go) begin
            wait_q <= 1'b1;
        end else if (phy_done) begin
            wait_q <= 1'b0;
            if (err_set) begin
                abn_q <= 1'b1;
                st_q <= ST_STOP;
            end else begin
                unique case (st_q)
                    ST_START: st_q <= ST_ADDR_W;
                    ST_ADDR_W: st_q <= (!ld_q && quick_q) ? ST_STOP
                        : ST_INDEX;
                    ST_INDEX: st_q <= (ld_q || target_q[0]) ? ST_RESTART
                        : ST_DATA_W;
                    ST_DATA_W: st_q <= ST_STOP;
                    ST_RESTART: st_q <= ST_ADDR_R;
                    ST_ADDR_R: st_q <= ST_DATA_R;
                    ST_DATA_R: begin
                        if (ld_q && (idx_q == 5'd0)
                            && (phy_rx != EE_FLAG_LOAD)) begin
                            abn_q <= 1'b1;
                        end
                        if (!ld_q || abn_q || (idx_q == EE_LAST)) begin
                            st_q <= ST_STOP;
                        end else begin
                            idx_q <= idx_q + 5'd1;
                        end
                    end
                    ST_STOP: begin
                        st_q <= ST_IDLE;
                        busy_q <= 1'b0;
                        ld_q <= 1'b0;
                        dflt_valid_q <= dflt_valid_q
                            || (ld_q && !abn_q);
                    end
                    ST_BOOT, ST_IDLE: st_q <= ST_IDLE;
                endcase
            end
        end else if (sw_start) begin
            st_q <= ST_START;
            busy_q <= 1'b1;
            abn_q <= 1'b0;
        end
    end
    // ====================
    // Software registers
    always_ff @(posedge clock) begin
        if (rst) begin
            data_q <= REG_RST;
            index_q <= REG_RST;
            target_q <= REG_RST;
            quick_q <= 1'b0;
            cfg_rdata_q <= REG_RST;
        end else begin
            if (sw_rd) data_q <= phy_rx;
            else if (idle_wr && cfg_addr == REG_DATA) data_q <= cfg_wdata;
            if (idle_wr && cfg_addr == REG_INDEX) index_q <= cfg_wdata;
            if (sw_start) target_q <= cfg_wdata;
            if (idle_wr && ctrl_wr) quick_q <= cfg_wdata[CS_QUICK];
            if (cfg_rd) cfg_rdata_q <= rd_mux;
        end
    end
    // Status flags: a set in the same cycle as a clear wins.
    always_ff @(posedge clock) begin
        if (rst) begin
            rdv_q <= 1'b0;
            err_q <= 1'b0;
            det_q <= 1'b0;
        end else begin
            rdv_q <= sw_rd || (rdv_q && !sw_start);
            err_q <= err_set
                || (err_q && !(ctrl_wr && cfg_wdata[CS_ERR]));
            det_q <= det_set
                || (det_q && !(ctrl_wr && cfg_wdata[CS_DETECT]));
        end
    end
    // ====================
    // EEPROM image, masked per byte so unloaded bits stay zero
    for (genvar i = 0; i < EE_BYTES; i++) begin : g_ee
        always_ff @(posedge clock) begin
            if (rst) begin
                ee_q[i] <= 8'h00;
            end else if (store && idx_q == 5'(i)) begin
                ee_q[i] <= phy_rx & LOAD_MASK[i];
            end
        end
    end
    assign dflt_command = {ee_q[1][7], 1'b0, ee_q[1][6:5], 2'b00,
        ee_q[1][2:0]};
    assign dflt_subsys_vendor = {ee_q[3], ee_q[2]};
    assign dflt_subsys_id = {ee_q[5], ee_q[4]};
    assign legacy_base_address = {ee_q[9], ee_q[8], ee_q[7],
        ee_q[6]};
    assign dflt_sys_ctrl = {ee_q[13], ee_q[12], ee_q[11],
        ee_q[10]};
    assign dflt_route = {ee_q[17][3:0], ee_q[16], ee_q[15],
        ee_q[14]};
    assign dflt_retry = ee_q[18];
    assign dflt_card_ctrl = ee_q[19];
    assign dflt_dev_ctrl = ee_q[20];
    assign dflt_diag = ee_q[21];
    assign dflt_pm_cap15 = ee_q[22][7];
    assign dflt_socket_id = ee_q[23];
    assign dflt_force_evt27 = ee_q[24][3];
    // ====================
    // Checks
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    property p_start_busy;
        sw_start |=> busy_q && (st_q == ST_START);
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("Write to target did not start a transaction.");

    property p_detect_clear;
        ctrl_wr && cfg_wdata[CS_DETECT] && !det_set |=> !det_q;
    endproperty
    a_detect_clear: assert property (p_detect_clear)
        else $error("Detect flag not cleared by a one.");

    property p_scl_idle;
        !busy_q |-> !multipurpose_pin_four_oe;
    endproperty
    a_scl_idle: assert property (p_scl_idle)
        else $error("Serial clock driven while idle.");

    property p_flag_skip;
        rd_done && ld_q && (idx_q == 5'd0) && (phy_rx != EE_FLAG_LOAD)
            |=> abn_q ##1 !store [*8];
    endproperty
    a_flag_skip: assert property (p_flag_skip)
        else $error("Bad flag byte did not abandon the load.");

    property p_vendor_low;
        store && (idx_q == 5'd2) |=> ee_q[2] == $past(phy_rx);
    endproperty
    a_vendor_low: assert property (p_vendor_low)
        else $error("Vendor low byte not loaded.");

    property p_base_bit0;
        store && (idx_q == 5'd6) |=> (ee_q[6] == ($past(phy_rx) & 8'hFE));
    endproperty
    a_base_bit0: assert property (p_base_bit0)
        else $error("Base address low byte mask wrong.");

    property p_nack_err;
        phy_done && phy_nack && (st_q == ST_ADDR_W) |=> err_q
            && (st_q == ST_STOP);
    endproperty
    a_nack_err: assert property (p_nack_err)
        else $error("Missing acknowledge not reported.");

    property p_sw_read;
        sw_rd |=> rdv_q && (data_q == $past(phy_rx));
    endproperty
    a_sw_read: assert property (p_sw_read)
        else $error("Read byte not captured.");

    property p_ee_addr;
        phy_go && ld_q && (st_q == ST_ADDR_W) |-> tx_w == 8'hA0;
    endproperty
    a_ee_addr: assert property (p_ee_addr)
        else $error("EEPROM addressed at the wrong address.");

    property p_quick;
        phy_done && !phy_nack && (st_q == ST_ADDR_W) && !ld_q && quick_q
            |=> st_q == ST_STOP;
    endproperty
    a_quick: assert property (p_quick)
        else $error("Quick command sent more than the address.");
endmodule : sel_loader

// ### core/sel_pkg.sv
// Purpose: Constants and types of the serial EEPROM default loader.
// Assumes: 125 MHz clock, open-drain two-wire bus with pull-ups.
// Notes on behaviour
// - After reset, with the bus detected, read defaults from the EEPROM.
// - EEPROM byte 00h is a flag: 01h loads, FFh skips loading.
// - Byte 01h: command bit 8 from bit 7, bits 6-5 and 2-0 direct.
// - Bytes 02h/03h load low/high subsystem vendor identification.
// - Bytes 04h/05h load low/high subsystem identification.
// - Bytes 06h-09h load legacy base address, low byte bits 7-1 only.
// - Bytes 0Ah-0Dh load all 32 system control bits, low byte first.
// - Bytes 0Eh-11h load routing; byte 11h bits 3-0 fill bits 27-24.
// - Byte 12h loads retry bits 7,6; byte 13h card control bit 7.
// - Byte 14h loads device bits 6,3-0; byte 15h diagnostic 7,4-0.
// - Byte 16h bit 7 loads power capabilities bit 15.
// - Byte 17h loads all eight socket identification bits.
// - Byte 18h bit 3 loads force event bit 27 at socket offset 0Ch.
// - The EEPROM is addressed at seven-bit address 1010000b.
// - Software reaches the bus through four byte registers at B0h.
// - B0h holds the byte to send, or captures the byte read.
// - B1h is sent as word address, unused by the quick command.
// - Writing B2h starts a transaction; it holds address and direction.
// - B3h shows read valid, busy, error and holds protocol select.
// - Detect flag at B3h bit 3 sets on detection, cleared by 1.
// - Multi-byte reads come only from the reset-time loader.
// - A missing slave acknowledge sets the error status bit.
// - Clock runs near 100 kHz in transfers, released when idle.
package sel_pkg;
    // ====================
    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_PERIOD_NS = 10000;
    // Quarter bit, rounded up so the clock never exceeds 100 kHz.
    localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
        / (4 * CLK_PERIOD_NS);
    localparam int BOOT_WAIT = 3;
    // ====================
    // Registers
    localparam logic [7:0] REG_DATA = 8'hB0;
    localparam logic [7:0] REG_INDEX = 8'hB1;
    localparam logic [7:0] REG_TARGET = 8'hB2;
    localparam logic [7:0] REG_CTRL = 8'hB3;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int CS_QUICK = 0;
    localparam int CS_RDV = 1;
    localparam int CS_ERR = 2;
    localparam int CS_DETECT = 3;
    localparam int CS_BUSY = 5;
    // ====================
    // EEPROM image
    localparam logic [6:0] EE_ADDR7 = 7'h50;
    localparam logic [7:0] EE_FLAG_LOAD = 8'h01;
    localparam logic [7:0] EE_START = 8'h00;
    localparam int EE_BYTES = 25;
    localparam logic [4:0] EE_LAST = 5'h18;
    localparam logic [7:0] LOAD_MASK [0:EE_BYTES-1] = '{
        8'h00, 8'hE7, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
        8'hC0, 8'h80, 8'h4F, 8'h9F, 8'h80, 8'hFF, 8'h08};
    // ====================
    // Types
    typedef logic [7:0] sel_byte_t;
    typedef enum logic [1:0] {
        CMD_START = 2'b00,
        CMD_STOP = 2'b01,
        CMD_BYTE = 2'b10
    } sel_cmd_e;
    typedef enum logic [3:0] {
        ST_BOOT = 4'h0,
        ST_IDLE = 4'h1,
        ST_START = 4'h2,
        ST_ADDR_W = 4'h3,
        ST_INDEX = 4'h4,
        ST_DATA_W = 4'h5,
        ST_RESTART = 4'h6,
        ST_ADDR_R = 4'h7,
        ST_DATA_R = 4'h8,
        ST_STOP = 4'h9
    } sel_st_e;
endpackage : sel_pkg

// ### core/sel_i2c_phy.sv
// Purpose: Bit engine: start, stop and nine-bit byte slots on the bus.
// Assumes: Pins are open-drain; output enable high pulls the line low.
// Notes: A slave holding the clock low in a byte slot stretches the low phase.
`timescale 1ns/1ps
module sel_i2c_phy
    import sel_pkg::*;
#(
    parameter int QTR = QTR_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Command
    input wire logic go,
    input wire sel_cmd_e cmd,
    input wire sel_byte_t tx,
    input wire logic ack_out,
    output logic done_q,
    output sel_byte_t rx_q,
    output logic nack_q,
    // Pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_q,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_q
);
    localparam int QW = $clog2(QTR);
    // ====================
    // Synchronisers
    logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;
    always_ff @(posedge clock) begin
        scl_m_q <= scl_i;
        scl_s_q <= scl_m_q;
        sda_m_q <= sda_i;
        sda_s_q <= sda_m_q;
    end
    // ====================
    // Quarter-bit divider
    logic busy_q;
    sel_cmd_e cmd_q;
    logic [1:0] qc_q;
    logic [3:0] bc_q;
    logic [8:0] sh_q;
    logic [QW-1:0] div_q;
    wire tick = busy_q && (div_q == '0);
    wire hold = (cmd_q == CMD_BYTE) && (qc_q == 2'd2) && !scl_s_q;
    wire step = tick && !hold;
    wire fin = step && (qc_q == 2'd3)
        && ((cmd_q != CMD_BYTE) || (bc_q == 4'd8));
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    always_ff @(posedge clock) begin
        if (rst || !busy_q || tick) begin
            div_q <= QW'(QTR - 1);
        end else begin
            div_q <= div_q - 1'b1;
        end
    end
    // ====================
    // Sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            cmd_q <= CMD_STOP;
            qc_q <= 2'd0;
            bc_q <= 4'd0;
            sh_q <= '0;
            rx_q <= '0;
            nack_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            done_q <= fin;
            if (go && !busy_q) begin
                busy_q <= 1'b1;
                cmd_q <= cmd;
                qc_q <= 2'd0;
                bc_q <= 4'd0;
                sh_q <= {tx, ack_out};
            end else if (step) begin
                qc_q <= qc_q + 2'd1;
                unique case (cmd_q)
                    CMD_START: begin
                        if (qc_q == 2'd0) sda_oe_q <= 1'b0;
                        if (qc_q == 2'd1) scl_oe_q <= 1'b0;
                        if (qc_q == 2'd2) sda_oe_q <= 1'b1;
                        if (qc_q == 2'd3) scl_oe_q <= 1'b1;
                    end
                    CMD_STOP: begin
                        if (qc_q == 2'd0) sda_oe_q <= 1'b1;
                        if (qc_q == 2'd1) scl_oe_q <= 1'b0;
                        if (qc_q == 2'd2) sda_oe_q <= 1'b0;
                    end
                    CMD_BYTE: begin
                        if (qc_q == 2'd0) sda_oe_q <= !sh_q[8];
                        if (qc_q == 2'd1) scl_oe_q <= 1'b0;
                        if (qc_q == 2'd2) sh_q <= {sh_q[7:0], sda_s_q};
                        if (qc_q == 2'd3) begin
                            scl_oe_q <= 1'b1;
                            bc_q <= bc_q + 4'd1;
                        end
                    end
                    default: busy_q <= 1'b0;
                endcase
                if (fin) begin
                    busy_q <= 1'b0;
                    rx_q <= sh_q[8:1];
                    nack_q <= sh_q[0];
                end
            end
        end
    end
endmodule : sel_i2c_phy

// ### tb/sel_eeprom_model.sv
// Purpose: Behavioural serial EEPROM on the two-wire bus.
// Assumes: Lines have pull-ups; sda_oe high pulls data low.
// Notes: Word address first; a master nack ends a read.
`timescale 1ns/1ps
module sel_eeprom_model #(
    parameter logic [6:0] ADDR = 7'h50
) (
    // Bus
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe
);
    // ====================
    // Slave
    logic [7:0] mem [0:255];
    logic [7:0] sh, ptr;
    logic act, rd, rdp, adr, wa;
    int n;
    initial begin
        sda_oe = 1'b0;
        act = 1'b0;
    end
    always @(negedge sda) begin
        if (scl) begin
            act = 1'b1;
            rd = 1'b0;
            rdp = 1'b0;
            adr = 1'b1;
            n = 0;
        end
    end
    always @(posedge sda) begin
        if (scl) act = 1'b0;
    end
    always @(posedge scl) begin
        if (act) begin
            if (n < 8 && !rd) sh = {sh[6:0], sda};
            if (n == 8 && rd) begin
                if (sda) act = 1'b0;
                else begin
                    ptr = ptr + 8'h01;
                    sh = mem[ptr];
                end
            end
            n = (n == 8) ? 0 : n + 1;
        end
    end
    // Released data floats high through the pull-up, so no stale value.
    always @(negedge scl) begin
        if (n == 0) rd = rdp;
        if (!act) sda_oe = 1'b0;
        else if (n == 8 && !rd) begin
            if (adr && sh[7:1] != ADDR) act = 1'b0;
            else if (adr) begin
                rdp = sh[0];
                wa = !sh[0];
                sh = mem[ptr];
                sda_oe = 1'b1;
            end else if (wa) begin
                ptr = sh;
                wa = 1'b0;
                sda_oe = 1'b1;
            end else begin
                mem[ptr] = sh;
                ptr = ptr + 8'h01;
                sda_oe = 1'b1;
            end
            adr = 1'b0;
        end else if (rd && n < 8) sda_oe = !sh[7-n];
        else sda_oe = 1'b0;
    end
endmodule : sel_eeprom_model

// ### tb/tb.sv
// Purpose: Self-checking bench of the default loader.
// Assumes: Short bit time through QTR; EEPROM model on the bus.
// Notes: Registers are polled, so waits are bounded by loop counts.
`timescale 1ns/1ps
module tb
    import sel_pkg::*;
;
    // ====================
    // Signals
    logic clock, rst, cfg_wr, cfg_rd, strap, scl_oe, sda_oe, ee_oe;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata_q, v, ret, crd, dev, dia, soc;
    logic [7:0] e [0:24];
    logic [8:0] cmd;
    logic [15:0] ven, sid;
    logic [31:0] lba, sys;
    logic [27:0] rte;
    logic dv, pm, fe;
    int mismatches, tests_run;
    wire logic scl = !scl_oe;
    wire logic sda = !(sda_oe || ee_oe);
    sel_loader #(.QTR(4)) i_sel_loader (.clock(clock), .rst(rst),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
        .serial_strap(strap), .multipurpose_pin_four_i(scl),
        .multipurpose_pin_four_o(), .multipurpose_pin_four_oe(scl_oe),
        .multipurpose_pin_one_i(sda), .multipurpose_pin_one_o(),
        .multipurpose_pin_one_oe(sda_oe), .dflt_valid_q(dv),
        .dflt_command(cmd), .dflt_subsys_vendor(ven), .dflt_subsys_id(sid),
        .legacy_base_address(lba), .dflt_sys_ctrl(sys), .dflt_route(rte),
        .dflt_retry(ret), .dflt_card_ctrl(crd), .dflt_dev_ctrl(dev),
        .dflt_diag(dia), .dflt_pm_cap15(pm), .dflt_socket_id(soc),
        .dflt_force_evt27(fe));
    sel_eeprom_model i_sel_eeprom_model (.scl(scl), .sda(sda),
        .sda_oe(ee_oe));
    // ====================
    // Helpers
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge clock);
        cfg_wr = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge clock);
        cfg_rd = 1'b0;
        d = cfg_rdata_q;
    endtask : rd
    task idle;
        int k;
        k = 0;
        v = 8'h20;
        while (v[5] !== 1'b0 && k < 5000) begin
            rd(REG_CTRL, v);
            k++;
        end
        chk(v[5], 1'b0);
        chk(scl_oe, 1'b0);
    endtask : idle
    task do_reset;
        @(negedge clock);
        rst = 1'b1;
        repeat (4) @(negedge clock);
        rst = 1'b0;
    endtask : do_reset
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    // ====================
    // Scenarios
    task t_boot;
        for (int i = 0; i < 25; i++) begin
            e[i] = (i == 0) ? 8'h01 : 8'h5B + i * 8'h37;
            i_sel_eeprom_model.mem[i] = e[i];
        end
        do_reset;
        repeat (8) @(negedge clock);
        rd(REG_CTRL, v);
        chk(v, 8'h28);
        idle;
        chk(dv, 1'b1);
        chk(cmd, {e[1][7], 1'b0, e[1][6:5], 2'b00, e[1][2:0]});
        chk(ven, {e[3], e[2]});
        chk(sid, {e[5], e[4]});
        chk(lba, {e[9], e[8], e[7], e[6][7:1], 1'b0});
        chk(sys, {e[13], e[12], e[11], e[10]});
        chk(rte, {e[17][3:0], e[16], e[15], e[14]});
        chk({ret, crd}, {e[18] & 8'hC0, e[19] & 8'h80});
        chk({dev, dia}, {e[20] & 8'h4F, e[21] & 8'h9F});
        chk({pm, soc}, {e[22][7], e[23]});
        chk(fe, e[24][3]);
        wr(REG_CTRL, 8'h08);
        rd(REG_CTRL, v);
        chk(v, 8'h00);
        rd(8'hB4, v);
        chk(v, 8'h00);
        $display("test boot done");
    endtask : t_boot
    task t_write_read;
        wr(REG_DATA, 8'hC3);
        wr(REG_INDEX, 8'h40);
        wr(REG_TARGET, {EE_ADDR7, 1'b0});
        idle;
        chk(i_sel_eeprom_model.mem[8'h40], 8'hC3);
        i_sel_eeprom_model.mem[8'h41] = 8'h9A;
        wr(REG_INDEX, 8'h41);
        wr(REG_TARGET, {EE_ADDR7, 1'b1});
        idle;
        rd(REG_CTRL, v);
        chk(v, 8'h02);
        rd(REG_DATA, v);
        chk(v, 8'h9A);
        $display("test write read done");
    endtask : t_write_read
    task t_nack_quick;
        wr(REG_TARGET, {7'h21, 1'b0});
        idle;
        rd(REG_CTRL, v);
        chk(v, 8'h04);
        wr(REG_CTRL, 8'h05);
        i_sel_eeprom_model.mem[8'h42] = 8'h77;
        wr(REG_INDEX, 8'h42);
        wr(REG_TARGET, {EE_ADDR7, 1'b0});
        idle;
        rd(REG_CTRL, v);
        chk(v, 8'h01);
        chk(i_sel_eeprom_model.mem[8'h42], 8'h77);
        // The model's current byte has its top bit set, so it frees the line.
        wr(REG_TARGET, {EE_ADDR7, 1'b1});
        idle;
        chk(i_sel_eeprom_model.rdp, 1'b1);
        rd(REG_CTRL, v);
        chk(v, 8'h01);
        rd(REG_DATA, v);
        chk(v, 8'h9A);
        wr(REG_CTRL, 8'h00);
        $display("test nack quick done");
    endtask : t_nack_quick
    task t_skip;
        i_sel_eeprom_model.mem[0] = 8'hFF;
        do_reset;
        repeat (8) @(negedge clock);
        idle;
        chk({dv, ven, soc}, 32'h0);
        $display("test skip done");
    endtask : t_skip
    // ====================
    // Run
    initial begin
        clock = 1'b0;
        forever #4 clock = !clock;
    end
    initial begin
        #500000;
        mismatches++;
        report_and_stop;
    end
    initial begin
        mismatches = 0;
        tests_run = 0;
        rst = 1'b1;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
        strap = 1'b1;
        t_boot;
        t_write_read;
        t_nack_quick;
        t_skip;
        report_and_stop;
    end
endmodule : tb
